//--- sample_status_pkg.sv
`default_nettype none
package sample_status_pkg;

  // ************************************************************
  // register addresses
  // ************************************************************
  localparam logic [7:0] ADDR_STATUS_ALIAS  = 8'h00;
  localparam logic [7:0] ADDR_P_HIGH        = 8'h01;
  localparam logic [7:0] ADDR_P_MID         = 8'h02;
  localparam logic [7:0] ADDR_P_LOW         = 8'h03;
  localparam logic [7:0] ADDR_T_HIGH        = 8'h04;
  localparam logic [7:0] ADDR_T_LOW         = 8'h05;
  localparam logic [7:0] ADDR_SAMPLE_STATUS = 8'h06;
  localparam logic [7:0] ADDR_FIFO_STATUS   = 8'h0d;
  localparam logic [7:0] ADDR_FIFO_DATA     = 8'h0e;
  localparam logic [7:0] ADDR_MAP_LAST      = 8'h2d;
  localparam logic [7:0] ADDR_MAP_WRAP      = 8'h0c;

  // ************************************************************
  // sample status field positions
  // ************************************************************
  localparam int BIT_COMBINED_OW = 7;
  localparam int BIT_PRESSURE_OW = 6;
  localparam int BIT_TEMP_OW     = 5;
  localparam int BIT_COMBINED_RDY = 3;
  localparam int BIT_PRESSURE_RDY = 2;
  localparam int BIT_TEMP_RDY     = 1;

  localparam logic [7:0] SAMPLE_STATUS_RESET = 8'h00;
  localparam logic [7:0] SAMPLE_STATUS_MASK  = 8'hee;
  localparam logic [7:0] ADDR_RESET          = 8'h00;
  localparam logic [7:0] RD_DATA_RESET       = 8'h00;
  localparam logic [3:0] LOW_NIBBLE_ZERO     = 4'h0;

  // ************************************************************
  // fifo mode field decode
  // ************************************************************
  typedef enum logic [1:0] {
    fifo_off,
    fifo_circular,
    fifo_stop_full,
    fifo_reserved
  } fifo_mode_e;

endpackage : sample_status_pkg
`default_nettype wire

//--- flag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flag_if;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] flags;

  modport ctrl (output set_vec, output clr_vec, input flags);
  modport core (input set_vec, input clr_vec, output flags);
endinterface : flag_if
`default_nettype wire

//--- sample_flag_bank.sv
`timescale 1ns/1ps
`default_nettype none
module sample_flag_bank (
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  flag_if.core      fl
);

  logic [7:0] flags_reg;
  logic [7:0] flags_next;

  // ************************************************************
  // sticky flags, one cell per bit
  // ************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // reserved bits never set, so they read as zero
      always_comb begin
        if (!sample_status_pkg::SAMPLE_STATUS_MASK[gi]) begin
          flags_next[gi] = 1'b0;
        end else if (fl.set_vec[gi]) begin
          flags_next[gi] = 1'b1;
        end else if (fl.clr_vec[gi]) begin
          flags_next[gi] = 1'b0;
        end else begin
          flags_next[gi] = flags_reg[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      flags_reg <= sample_status_pkg::SAMPLE_STATUS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign fl.flags = flags_reg;

endmodule : sample_flag_bank
`default_nettype wire

//--- sample_status_flags.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - fifo mode 00: address 00h reads the sample status register at 06h.
// - fifo mode nonzero: address 00h reads the fifo status at 0dh.
// - status alias lets a burst continue into data with auto address increment.
// - sample status: 8 bit read-only, reset zero, bits 7,6,5,3,2,1 flags.
// - flags track real-time updates of pressure and temperature outputs per sample.
// - combined overwrite sets when new result overwrites unretrieved previous set.
// - combined overwrite clears on p/t high byte read, or fifo data read.
// - pressure overwrite sets when pressure completes before previous was retrieved.
// - pressure overwrite clears on pressure high byte read, or fifo data read.
// - temperature overwrite sets when temperature completes before previous retrieved.
// - temperature overwrite clears on temperature high read, or fifo data read.
// - combined ready sets whenever a new pressure or temperature result arrives.
// - combined ready clears on either high byte read, or fifo data read.
// - pressure ready sets each time a pressure acquisition completes.
// - pressure ready clears on pressure high byte read, or fifo data read.
// - temperature ready sets each time a temperature acquisition completes.
// - temperature ready clears on temperature high read, or fifo data read.
// - combined flags generated only while data ready event generator enabled.
// - pressure flags generated only while pressure event enable is 1.
// - temperature flags generated only while temperature event enable is 1.
// - fifo mode 00 disables fifo data port; data registers carry real-time status.
// - fifo mode decodes 00 off, 01 circular, 10 stop when full.
// - fifo off: pressure high byte at 01h, temperature high byte at 04h.
module sample_status_flags (
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  input  wire logic        i_addr_load,
  input  wire logic [7:0]  i_addr_value,
  input  wire logic        i_rd_req,
  output var  logic [7:0]  o_rd_data,
  output var  logic        o_rd_valid,
  output var  logic [7:0]  o_addr,
  output logic             o_fifo_pop,
  input  wire logic        i_p_done,
  input  wire logic        i_t_done,
  input  wire logic [19:0] i_p_sample,
  input  wire logic [11:0] i_t_sample,
  input  wire logic [1:0]  i_fifo_mode,
  input  wire logic        i_data_ready_event_gen,
  input  wire logic        i_pressure_event_enable,
  input  wire logic        i_temperature_event_enable,
  input  wire logic [7:0]  i_fifo_status,
  input  wire logic [7:0]  i_fifo_byte,
  input  wire logic [7:0]  i_other_rd_data,
  output var  logic [7:0]  o_sample_status
);

  // ************************************************************
  // mode decode and access address
  // ************************************************************
  sample_status_pkg::fifo_mode_e fifo_mode;
  logic                          fifo_on;
  logic [7:0]                    acc_addr;
  logic                          rd_p_high;
  logic                          rd_t_high;
  logic                          rd_fifo_data;

  always_comb begin
    fifo_mode = sample_status_pkg::fifo_mode_e'(i_fifo_mode);
    // circular, stop-when-full and the unused code all count as fifo on
    fifo_on   = (fifo_mode != sample_status_pkg::fifo_off);
  end

  // a pointer load in the same cycle as a read redirects that read
  assign acc_addr = i_addr_load ? i_addr_value : o_addr;

  always_comb begin
    rd_p_high    = 1'b0;
    rd_t_high    = 1'b0;
    rd_fifo_data = 1'b0;
    if (i_rd_req) begin
      if (!fifo_on) begin
        rd_p_high = (acc_addr == sample_status_pkg::ADDR_P_HIGH);
        rd_t_high = (acc_addr == sample_status_pkg::ADDR_T_HIGH);
      end else begin
        // fifo data is reachable at its own address and at the root pointer
        rd_fifo_data = (acc_addr == sample_status_pkg::ADDR_P_HIGH) ||
                       (acc_addr == sample_status_pkg::ADDR_FIFO_DATA);
      end
    end
  end

  // data port is dead while the fifo is off
  assign o_fifo_pop = rd_fifo_data;

  // ************************************************************
  // flag set and clear vectors
  // ************************************************************
  flag_if fl ();

  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  logic [7:0] cur;
  logic [1:0] ch_done;
  logic [1:0] ch_enable;
  logic [1:0] ch_hi_read;
  logic [7:0] ch_set_vec [2];
  logic [7:0] ch_clr_vec [2];

  assign cur        = fl.flags;
  // index 0 is the pressure channel, index 1 the temperature channel
  assign ch_done    = {i_t_done, i_p_done};
  assign ch_enable  = {i_temperature_event_enable, i_pressure_event_enable};
  assign ch_hi_read = {rd_t_high, rd_p_high};

  // ************************************************************
  // per channel ready and overwrite pair
  // ************************************************************
  genvar gc;
  generate
    for (gc = 0; gc < 2; gc++) begin : g_chan
      localparam int RDY_BIT = (gc == 0) ? sample_status_pkg::BIT_PRESSURE_RDY : sample_status_pkg::BIT_TEMP_RDY;
      localparam int OW_BIT  = (gc == 0) ? sample_status_pkg::BIT_PRESSURE_OW : sample_status_pkg::BIT_TEMP_OW;

      always_comb begin
        ch_set_vec[gc] = 8'h00;
        ch_clr_vec[gc] = 8'h00;
        if (ch_enable[gc] && ch_done[gc]) begin
          ch_set_vec[gc][RDY_BIT] = 1'b1;
          // overwrite means the previous result was still unread
          ch_set_vec[gc][OW_BIT] = cur[RDY_BIT];
        end
        // clears by high byte read, fifo off
        if (ch_hi_read[gc]) begin
          ch_clr_vec[gc][RDY_BIT] = 1'b1;
          ch_clr_vec[gc][OW_BIT]  = 1'b1;
        end
      end
    end
  endgenerate

  // ************************************************************
  // combined pair and fifo data clear
  // ************************************************************
  always_comb begin
    set_vec = ch_set_vec[0] | ch_set_vec[1];
    clr_vec = ch_clr_vec[0] | ch_clr_vec[1];

    // combined pair follows either sample
    if (i_data_ready_event_gen && (|ch_done)) begin
      set_vec[sample_status_pkg::BIT_COMBINED_RDY] = 1'b1;
      set_vec[sample_status_pkg::BIT_COMBINED_OW] =
        cur[sample_status_pkg::BIT_COMBINED_RDY];
    end

    if (|ch_hi_read) begin
      clr_vec[sample_status_pkg::BIT_COMBINED_RDY] = 1'b1;
      clr_vec[sample_status_pkg::BIT_COMBINED_OW]  = 1'b1;
    end

    // one fifo data read clears every flag not set in the same cycle
    if (rd_fifo_data) begin
      clr_vec = sample_status_pkg::SAMPLE_STATUS_MASK;
    end
  end

  assign fl.set_vec = set_vec;
  assign fl.clr_vec = clr_vec;

  sample_flag_bank u_flag_bank (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .fl        (fl.core)
  );

  assign o_sample_status = fl.flags;

  // ************************************************************
  // read data mux
  // ************************************************************
  logic [7:0] rd_mux;

  always_comb begin
    rd_mux = 8'h00;
    if (!fifo_on) begin
      case (acc_addr)
        sample_status_pkg::ADDR_STATUS_ALIAS: begin
          rd_mux = fl.flags;
        end
        sample_status_pkg::ADDR_P_HIGH: begin
          rd_mux = i_p_sample[19:12];
        end
        sample_status_pkg::ADDR_P_MID: begin
          rd_mux = i_p_sample[11:4];
        end
        sample_status_pkg::ADDR_P_LOW: begin
          rd_mux = {i_p_sample[3:0], sample_status_pkg::LOW_NIBBLE_ZERO};
        end
        sample_status_pkg::ADDR_T_HIGH: begin
          rd_mux = i_t_sample[11:4];
        end
        sample_status_pkg::ADDR_T_LOW: begin
          rd_mux = {i_t_sample[3:0], sample_status_pkg::LOW_NIBBLE_ZERO};
        end
        sample_status_pkg::ADDR_SAMPLE_STATUS: begin
          rd_mux = fl.flags;
        end
        sample_status_pkg::ADDR_FIFO_STATUS: begin
          rd_mux = i_fifo_status;
        end
        // disabled data port reads as zero
        sample_status_pkg::ADDR_FIFO_DATA: begin
          rd_mux = 8'h00;
        end
        default: begin
          rd_mux = i_other_rd_data;
        end
      endcase
    end else begin
      case (acc_addr)
        sample_status_pkg::ADDR_STATUS_ALIAS: begin
          rd_mux = i_fifo_status;
        end
        sample_status_pkg::ADDR_P_HIGH: begin
          rd_mux = i_fifo_byte;
        end
        sample_status_pkg::ADDR_P_MID: begin
          rd_mux = 8'h00;
        end
        sample_status_pkg::ADDR_P_LOW: begin
          rd_mux = 8'h00;
        end
        sample_status_pkg::ADDR_T_HIGH: begin
          rd_mux = 8'h00;
        end
        sample_status_pkg::ADDR_T_LOW: begin
          rd_mux = 8'h00;
        end
        sample_status_pkg::ADDR_SAMPLE_STATUS: begin
          rd_mux = fl.flags;
        end
        sample_status_pkg::ADDR_FIFO_STATUS: begin
          rd_mux = i_fifo_status;
        end
        sample_status_pkg::ADDR_FIFO_DATA: begin
          rd_mux = i_fifo_byte;
        end
        default: begin
          rd_mux = i_other_rd_data;
        end
      endcase
    end
  end

  // ************************************************************
  // register pointer auto increment
  // ************************************************************
  logic [7:0] addr_inc;

  always_comb begin
    addr_inc = acc_addr + 8'h01;
    if (acc_addr == sample_status_pkg::ADDR_T_LOW) begin
      // status and samples form one six byte loop
      addr_inc = sample_status_pkg::ADDR_STATUS_ALIAS;
    end else if (fifo_on && acc_addr == sample_status_pkg::ADDR_P_HIGH) begin
      // the fifo root pointer stays put so a burst drains the fifo
      addr_inc = sample_status_pkg::ADDR_P_HIGH;
    end else if (acc_addr == sample_status_pkg::ADDR_MAP_LAST) begin
      addr_inc = sample_status_pkg::ADDR_MAP_WRAP;
    end
  end

  // ************************************************************
  // read port registers
  // ************************************************************
  logic [7:0] addr_reg;
  logic [7:0] addr_next;
  logic [7:0] rd_data_reg;
  logic [7:0] rd_data_next;
  logic       rd_valid_reg;
  logic       rd_valid_next;

  always_comb begin
    addr_next     = addr_reg;
    rd_data_next  = rd_data_reg;
    rd_valid_next = 1'b0;
    if (i_rd_req) begin
      addr_next     = addr_inc;
      rd_data_next  = rd_mux;
      rd_valid_next = 1'b1;
    end else if (i_addr_load) begin
      addr_next = i_addr_value;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      addr_reg     <= sample_status_pkg::ADDR_RESET;
      rd_data_reg  <= sample_status_pkg::RD_DATA_RESET;
      rd_valid_reg <= 1'b0;
    end else begin
      addr_reg     <= addr_next;
      rd_data_reg  <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign o_addr     = addr_reg;
  assign o_rd_data  = rd_data_reg;
  assign o_rd_valid = rd_valid_reg;

endmodule : sample_status_flags
`default_nettype wire

//--- sample_status_flags_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module sample_status_flags_assertions (
  input wire logic       i_clk_sys,
  input wire logic       i_srst,
  input wire logic       i_addr_load,
  input wire logic [7:0] i_addr_value,
  input wire logic       i_rd_req,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic [7:0] o_addr,
  input wire logic       o_fifo_pop,
  input wire logic       i_p_done,
  input wire logic       i_t_done,
  input wire logic [1:0] i_fifo_mode,
  input wire logic       i_data_ready_event_gen,
  input wire logic       i_pressure_event_enable,
  input wire logic [7:0] i_fifo_status,
  input wire logic [7:0] o_sample_status
);
  logic [7:0] ea;
  logic       rd0;
  logic       idle;
  assign ea   = i_addr_load ? i_addr_value : o_addr;
  assign rd0  = i_rd_req && i_fifo_mode == 2'b00;
  assign idle = !i_p_done && !i_t_done;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  sequence p_clr_s; rd0 && ea == 8'h01 && idle; endsequence
  sequence pop_s; o_fifo_pop && idle; endsequence
  alias_status_a: assert property (rd0 && ea == 8'h00 |=> o_rd_data == $past(o_sample_status))
    else $error("alias not sample status");
  alias_fifo_a: assert property (i_rd_req && i_fifo_mode != 2'b00 && ea == 8'h00
    |=> o_rd_data == $past(i_fifo_status)) else $error("alias not fifo status");
  burst_advance_a: assert property (rd0 && ea < 8'h05 |=> o_rd_valid && o_addr == $past(ea) + 8'h01)
    else $error("pointer did not advance");
  burst_wrap_a: assert property (rd0 && ea == 8'h05 |=> o_addr == 8'h00)
    else $error("pointer did not wrap");
  reserved_zero_a: assert property (o_sample_status[4] == 1'b0 && o_sample_status[0] == 1'b0)
    else $error("reserved bit set");
  p_set_a: assert property (i_p_done && i_pressure_event_enable
    |=> o_sample_status[2] && o_sample_status[6] == $past(o_sample_status[2])) else $error("pressure set");
  comb_set_a: assert property ((i_p_done || i_t_done) && i_data_ready_event_gen
    |=> o_sample_status[3] && o_sample_status[7] == $past(o_sample_status[3])) else $error("combined set");
  comb_gate_a: assert property (!i_data_ready_event_gen && !o_sample_status[3] |=> !o_sample_status[3])
    else $error("combined set while gated");
  p_clear_a: assert property (p_clr_s |=> (o_sample_status & 8'hcc) == 8'h00)
    else $error("pressure read did not clear");
  fifo_clear_a: assert property (pop_s |=> o_sample_status == 8'h00)
    else $error("fifo read did not clear");
  pop_decode_a: assert property (o_fifo_pop == (i_rd_req && i_fifo_mode != 2'b00
    && (ea == 8'h01 || ea == 8'h0e))) else $error("fifo pop decode");
  status_keep_a: assert property (i_rd_req && ea == 8'h06 && idle |=> $stable(o_sample_status))
    else $error("status read changed flags");
endmodule : sample_status_flags_assertions
bind sample_status_flags sample_status_flags_assertions chk_u (.*);
`default_nettype wire

//--- host_reader.sv
`timescale 1ns/1ps
`default_nettype none
module host_reader (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rd_valid,
  input  wire logic [7:0] i_rd_data,
  output var  logic       o_addr_load,
  output var  logic [7:0] o_addr_value,
  output var  logic       o_rd_req
);
  initial begin
    o_addr_load  = 1'b0;
    o_addr_value = 8'h5a;
    o_rd_req     = 1'b0;
  end
  // gap idles the host first, so slow masters are covered
  task automatic rd(input int gap, input logic ld, input logic [7:0] a, output logic [7:0] d, output logic v);
    repeat (gap + 1) @(posedge i_clk_sys);
    #1;
    o_addr_load  = ld;
    o_addr_value = a;
    o_rd_req     = 1'b1;
    @(posedge i_clk_sys);
    #1;
    o_addr_load  = 1'b0;
    o_addr_value = ~a;
    o_rd_req     = 1'b0;
    d = i_rd_data;
    v = i_rd_valid;
  endtask : rd
endmodule : host_reader
`default_nettype wire

//--- sample_status_flags_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sample_status_flags_tb;
  logic        clk = 1'b0;
  logic        srst, ld, rq, rv, pop, pop_q, pd, td, data_ready_event_gen, pen, ten, v;
  logic [7:0]  av, rdata, ptr, sts, fst, fby, oth, expf, eptr, d;
  logic [19:0] ps;
  logic [11:0] ts;
  logic [1:0]  mode;
  logic [31:0] seed;
  logic [7:0]  tbl [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0d, 8'h0e, 8'h2d, 8'h10};
  int          error_cnt, check_count;
  always #2 clk = ~clk;
  // pop is a same-cycle pulse, so it is caught at the edge that takes the read
  always @(posedge clk) pop_q <= pop;
  sample_status_flags dut_u (.i_clk_sys(clk), .i_srst(srst), .i_addr_load(ld), .i_addr_value(av),
    .i_rd_req(rq), .o_rd_data(rdata), .o_rd_valid(rv), .o_addr(ptr), .o_fifo_pop(pop), .i_p_done(pd),
    .i_t_done(td), .i_p_sample(ps), .i_t_sample(ts), .i_fifo_mode(mode), .i_data_ready_event_gen(data_ready_event_gen),
    .i_pressure_event_enable(pen), .i_temperature_event_enable(ten), .i_fifo_status(fst),
    .i_fifo_byte(fby), .i_other_rd_data(oth), .o_sample_status(sts));
  host_reader host_u (.i_clk_sys(clk), .i_rd_valid(rv), .i_rd_data(rdata), .o_addr_load(ld),
    .o_addr_value(av), .o_rd_req(rq));
  // ****************
  // expectations
  // ****************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  function automatic logic [7:0] exp_rd(input logic [7:0] a);
    if (mode == 2'b00) begin
      case (a)
        8'h00, 8'h06: return expf;
        8'h01: return ps[19:12];
        8'h02: return ps[11:4];
        8'h03: return {ps[3:0], 4'h0};
        8'h04: return ts[11:4];
        8'h05: return {ts[3:0], 4'h0};
        8'h0d: return fst;
        8'h0e: return 8'h00;
        default: return oth;
      endcase
    end
    case (a)
      8'h00, 8'h0d: return fst;
      8'h01, 8'h0e: return fby;
      8'h02, 8'h03, 8'h04, 8'h05: return 8'h00;
      8'h06: return expf;
      default: return oth;
    endcase
  endfunction : exp_rd
  function automatic logic [7:0] exp_ptr(input logic [7:0] a);
    if (a == 8'h05) return 8'h00;
    if (a == 8'h01 && mode != 2'b00) return 8'h01;
    if (a == 8'h2d) return 8'h0c;
    return a + 8'h01;
  endfunction : exp_ptr
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : cmp
  // clear is applied before set: a set in the same cycle wins
  // overwrite looks at the ready flag held before that cycle's clear
  task automatic upd(input logic [7:0] a, input logic rd, input logic p, input logic t);
    logic [7:0] o;
    o = expf;
    if (rd && mode != 2'b00 && (a == 8'h01 || a == 8'h0e)) expf = 8'h00;
    if (rd && mode == 2'b00 && a == 8'h01) expf &= 8'h33;
    if (rd && mode == 2'b00 && a == 8'h04) expf &= 8'h55;
    if (p && pen) expf = {expf[7], o[2], expf[5:3], 1'b1, expf[1:0]};
    if (t && ten) expf = {expf[7:6], o[1], expf[4:2], 1'b1, expf[0]};
    if ((p || t) && data_ready_event_gen) expf = {o[3], expf[6:4], 1'b1, expf[2:0]};
  endtask : upd
  task automatic acq(input int gap, input logic p, input logic t);
    repeat (gap + 1) @(posedge clk);
    #1;
    pd = p;
    td = t;
    @(posedge clk);
    #1;
    pd = 1'b0;
    td = 1'b0;
  endtask : acq
  task automatic ev(input logic p, input logic t);
    acq(0, p, t);
    upd(8'h00, 1'b0, p, t);
    cmp("flags", expf, sts);
  endtask : ev
  task automatic rd_op(input int gap, input logic l, input logic [7:0] a, input logic p, input logic t);
    logic [7:0] ea;
    logic [7:0] e;
    logic       ep;
    ea = l ? a : eptr;
    e  = exp_rd(ea);
    ep = (mode != 2'b00) && (ea == 8'h01 || ea == 8'h0e);
    fork
      host_u.rd(gap, l, a, d, v);
      acq(gap, p, t);
    join
    upd(ea, 1'b1, p, t);
    eptr = exp_ptr(ea);
    cmp("read data", e, d);
    cmp("read valid", 8'h01, {7'h00, v});
    cmp("pointer", eptr, ptr);
    cmp("fifo pop", {7'h00, ep}, {7'h00, pop_q});
    cmp("flags", expf, sts);
  endtask : rd_op
  task automatic summarize();
    if (error_cnt == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    #60000;
    error_cnt++;
    summarize();
  end
  initial begin
    seed = 32'ha744;
    {srst, pd, td, mode, data_ready_event_gen, pen, ten, expf, eptr} = {1'b1, 7'h0f, 16'h0000};
    {ps, ts, fst, fby, oth} = {20'h12345, 12'habc, 8'h3c, 8'hc3, 8'h96};
    repeat (6) @(posedge clk);
    #1;
    srst = 1'b0;
    cmp("flags", 8'h00, sts);
    cmp("pointer", 8'h00, ptr);
    ev(1'b1, 1'b1);
    ev(1'b1, 1'b1);
    rd_op(0, 1'b1, 8'h00, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) rd_op(0, 1'b0, 8'h00, 1'b0, 1'b0);
    ev(1'b1, 1'b0);
    rd_op(0, 1'b1, 8'h01, 1'b1, 1'b0);
    for (int i = 0; i < 300; i++) begin
      seed = lfsr(seed);
      if (seed[7:5] == 3'h0) mode = seed[9:8];
      {data_ready_event_gen, pen, ten} = {|seed[12:11], |seed[14:13], |seed[16:15]};
      {fst, fby, oth} = seed[31:8];
      if (seed[17]) begin
        {ps, ts} = {seed[31:12], seed[27:16]};
        ev(seed[18], seed[19]);
      end else
        rd_op(seed[21:20], seed[22], tbl[seed[26:23] % 4'd11], seed[27] & seed[28], seed[29] & seed[30]);
    end
    summarize();
  end
endmodule : sample_status_flags_tb
`default_nettype wire
